// ---- rtl/gpcko_bank.sv ----
/*
 * General-purpose pin and clock output control bank with an AHB-Lite register slave.
 * Assumes one slave on the bus, word transfers, and pin levels synchronous to hclk.
 */
// Local design decision: register access over AHB-Lite.

// What this block does
// - Auxiliary clock enable bit 15 gates the auxiliary clock pin; resets off.
// - Auxiliary frequency 14:13 picks 25, 50 or 125 MHz; 11 reserved.
// - Active-low direction bit 13 makes hold pin input at 1, output at 0.
// - Hold pin as output drives data bit 12, reset 0.
// - Read-only bit 11 returns the sampled hold pin level.
// - LED tri-state bit 9 releases LEDs instead of driving high; resets set.
// - Alert field 3:0 enables alert pin at 0000, disables at 1111.
// - Line clock enable bit 15 turns the line-derived clock on; resets off.
// - Line frequency 10:8 picks 25, 125 or 31.25 MHz; others reserved.
// - Squelch 00 holds clock low when down, unstable, unsupported mode or EEE.
// - Squelch 01 as 00 but runs for gig master, 10M and LPI receive.
// - Squelch 10 holds the clock low only while link is down.
// - Squelch 11 never holds the clock, even with link down.
// - High clock-mute pin squelches line clocks regardless of settings.
// - Source 2:0 selects copper recovered clock at 001; others reserved.
// - Writable bank bits survive software reset; only hardware reset clears them.
module gpcko_bank
	import gpcko_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic soft_reset,
	input wire logic [2:0] aux_clock_src,
	output logic aux_clock_output,
	input wire logic low_power_hold_pin_in,
	output logic low_power_hold_pin_out,
	output logic low_power_hold_pin_oe,
	input wire logic [GPCKO_LED_COUNT-1:0] led_level,
	output logic [GPCKO_LED_COUNT-1:0] led_out,
	output logic [GPCKO_LED_COUNT-1:0] led_oe,
	input wire logic link_loss_event,
	output logic link_loss_alert_pin,
	input wire logic [2:0] line_clock_src,
	input wire gpcko_link_type link_status,
	input wire logic clock_mute_pin,
	output logic line_derived_clock_output
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Register read image; reserved positions stay zero
	function automatic logic [15:0] reg_image(input logic [4:0] idx, input gpcko_cfg_type c,
		input logic pin_lvl, input logic [15:0] page);
		logic [15:0] v;
		v = 16'h0000;
		case (idx)
			GPCKO_IDX_AUX: begin
				v[GPCKO_AUX_EN_BIT] = c.aux_en;
				v[GPCKO_AUX_FREQ_LSB+:2] = c.aux_freq;
			end
			GPCKO_IDX_HOLD: begin
				v[GPCKO_HOLD_DIR_N_BIT] = c.hold_dir_n;
				v[GPCKO_HOLD_DATA_BIT] = c.hold_data;
				v[GPCKO_HOLD_IN_BIT] = pin_lvl;
				v[GPCKO_LED_TRI_BIT] = c.led_tri;
			end
			GPCKO_IDX_ALERT: begin
				v[GPCKO_ALERT_LSB+:4] = c.alert_sel;
			end
			GPCKO_IDX_LINE: begin
				v[GPCKO_LINE_EN_BIT] = c.line_en;
				v[GPCKO_LINE_FREQ_LSB+:3] = c.line_freq;
				v[GPCKO_LINE_SQ_LSB+:2] = c.line_sq;
				v[GPCKO_LINE_SRC_LSB+:3] = c.line_src;
			end
			GPCKO_IDX_PAGE: begin
				v = page;
			end
			default: begin
				v = 16'h0000;
			end
		endcase
		return v;
	endfunction

	// Apply a write; only documented writable fields are stored
	function automatic gpcko_cfg_type reg_store(input logic [4:0] idx, input gpcko_cfg_type c,
		input logic [15:0] d);
		gpcko_cfg_type n;
		n = c;
		case (idx)
			GPCKO_IDX_AUX: begin
				n.aux_en = d[GPCKO_AUX_EN_BIT];
				n.aux_freq = d[GPCKO_AUX_FREQ_LSB+:2];
			end
			GPCKO_IDX_HOLD: begin
				n.hold_dir_n = d[GPCKO_HOLD_DIR_N_BIT];
				n.hold_data = d[GPCKO_HOLD_DATA_BIT];
				n.led_tri = d[GPCKO_LED_TRI_BIT];
			end
			GPCKO_IDX_ALERT: begin
				n.alert_sel = d[GPCKO_ALERT_LSB+:4];
			end
			GPCKO_IDX_LINE: begin
				n.line_en = d[GPCKO_LINE_EN_BIT];
				n.line_freq = d[GPCKO_LINE_FREQ_LSB+:3];
				n.line_sq = gpcko_squelch_type'(d[GPCKO_LINE_SQ_LSB+:2]);
				n.line_src = d[GPCKO_LINE_SRC_LSB+:3];
			end
			default: begin
				n = c;
			end
		endcase
		return n;
	endfunction

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire logic bus_take = hsel && hready && (htrans == GPCKO_HTRANS_NONSEQ || htrans == GPCKO_HTRANS_SEQ);
	wire logic [4:0] addr_idx = haddr[GPCKO_IDX_MSB:GPCKO_IDX_LSB];

	logic wr_pend_r;
	logic [4:0] wr_idx_r;
	logic [15:0] page_r;
	logic [15:0] page_nxt;
	gpcko_cfg_type cfg_r;
	gpcko_cfg_type cfg_nxt;
	logic pin_lvl_r;
	logic [31:0] rdata_nxt;

	// Bank fields are visible only while the general page is mapped
	wire logic page_general = (page_r == GPCKO_PAGE_GENERAL);
	wire logic wr_page = wr_pend_r && (wr_idx_r == GPCKO_IDX_PAGE);
	wire logic wr_bank = wr_pend_r && page_general && (wr_idx_r != GPCKO_IDX_PAGE);
	wire logic rd_visible = page_general || (addr_idx == GPCKO_IDX_PAGE);

	// ----------------------------------------------------------------
	// Next-state selection
	// ----------------------------------------------------------------
	// Soft reset returns to the main page, but a page write in the same cycle wins; the bank stays untouched
	always_comb begin
		page_nxt = page_r;
		if (soft_reset) begin
			page_nxt = GPCKO_PAGE_MAIN;
		end
		if (wr_page) begin
			page_nxt = hwdata[15:0];
		end
	end

	always_comb begin
		cfg_nxt = cfg_r;
		if (wr_bank) begin
			cfg_nxt = reg_store(wr_idx_r, cfg_r, hwdata[15:0]);
		end
	end

	// Read data is captured at the address phase so it stands in a zero-wait data phase
	always_comb begin
		rdata_nxt = hrdata;
		if (bus_take && !hwrite) begin
			rdata_nxt = 32'h00000000;
			if (rd_visible) begin
				rdata_nxt[15:0] = reg_image(addr_idx, cfg_r, pin_lvl_r, page_r);
			end
		end
	end

	// ----------------------------------------------------------------
	// Bus and register state
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_idx_r <= 5'h00;
		end else begin
			wr_pend_r <= bus_take && hwrite;
			wr_idx_r <= addr_idx;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			page_r <= GPCKO_PAGE_RST;
		end else begin
			hrdata <= rdata_nxt;
			page_r <= page_nxt;
		end
	end

	// Only hardware reset reaches the configuration fields
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_r.aux_en <= GPCKO_AUX_EN_RST;
			cfg_r.aux_freq <= GPCKO_AUX_FREQ_RST;
			cfg_r.hold_dir_n <= GPCKO_HOLD_DIR_N_RST;
			cfg_r.hold_data <= GPCKO_HOLD_DATA_RST;
			cfg_r.led_tri <= GPCKO_LED_TRI_RST;
			cfg_r.alert_sel <= GPCKO_ALERT_RST;
			cfg_r.line_en <= GPCKO_LINE_EN_RST;
			cfg_r.line_freq <= GPCKO_LINE_FREQ_RST;
			cfg_r.line_sq <= GPCKO_SQ_AUTO;
			cfg_r.line_src <= GPCKO_LINE_SRC_RST;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// Single stage is enough: the pin level is taken as synchronous
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_lvl_r <= 1'b0;
		end else begin
			pin_lvl_r <= low_power_hold_pin_in;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = GPCKO_HRESP_OKAY;

	// ----------------------------------------------------------------
	// Hold pin, LEDs and alert pin
	// ----------------------------------------------------------------
	wire logic hold_oe_nxt = !cfg_r.hold_dir_n;
	wire logic hold_out_nxt = cfg_r.hold_data;
	// Tri-state mode lets an external pull-up set the high level
	wire logic [GPCKO_LED_COUNT-1:0] led_oe_nxt = cfg_r.led_tri ? ~led_level : {GPCKO_LED_COUNT{1'b1}};
	// Reserved alert codes are treated as disabled
	wire logic alert_on = (cfg_r.alert_sel == GPCKO_ALERT_ENABLED);
	wire logic alert_nxt = alert_on && link_loss_event;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_power_hold_pin_oe <= 1'b0;
			low_power_hold_pin_out <= 1'b0;
			led_oe <= '0;
			led_out <= '0;
			link_loss_alert_pin <= 1'b0;
		end else begin
			low_power_hold_pin_oe <= hold_oe_nxt;
			low_power_hold_pin_out <= hold_out_nxt;
			led_oe <= led_oe_nxt;
			led_out <= led_level;
			link_loss_alert_pin <= alert_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Line clock squelch
	// ----------------------------------------------------------------
	wire logic lk_down = !link_status.link_up;
	wire logic lk_unstable = !link_status.link_stable;
	wire logic lk_gig = (link_status.speed == GPCKO_SPEED_1000);
	wire logic lk_no_recovery = (lk_gig && link_status.gig_master) || (link_status.speed == GPCKO_SPEED_10);
	wire logic lk_eee = link_status.eee_mode &&
		((link_status.speed == GPCKO_SPEED_100) || (lk_gig && !link_status.gig_master));
	logic sq_policy;

	always_comb begin
		case (cfg_r.line_sq)
			GPCKO_SQ_AUTO: begin
				sq_policy = lk_down || lk_unstable || lk_no_recovery || lk_eee;
			end
			GPCKO_SQ_AUTO_PLUS: begin
				sq_policy = lk_down || lk_unstable || (lk_eee && !link_status.lpi_rx);
			end
			GPCKO_SQ_LINK_ONLY: begin
				sq_policy = lk_down;
			end
			GPCKO_SQ_NONE: begin
				sq_policy = 1'b0;
			end
			default: begin
				sq_policy = 1'b1;
			end
		endcase
	end

	// The mute pin wins over every register setting
	wire logic line_squelch = clock_mute_pin || sq_policy;
	// Only the copper recovered source is wired; reserved sources stay low
	wire logic line_src_ok = (cfg_r.line_src == GPCKO_LINE_SRC_COPPER);
	wire logic line_freq_ok = line_src_ok && (cfg_r.line_freq <= GPCKO_LINE_FREQ_MAX);

	// ----------------------------------------------------------------
	// Clock output gates
	// ----------------------------------------------------------------
	gpcko_clk_gate u_aux_gate (
		.hclk(hclk),
		.hresetn(hresetn),
		.enable(cfg_r.aux_en),
		.squelch(1'b0),
		.sel_valid(cfg_r.aux_freq != GPCKO_AUX_FREQ_RSVD),
		.sel(cfg_r.aux_freq),
		.src(aux_clock_src),
		.clk_out(aux_clock_output)
	);

	gpcko_clk_gate u_line_gate (
		.hclk(hclk),
		.hresetn(hresetn),
		.enable(cfg_r.line_en),
		.squelch(line_squelch),
		.sel_valid(line_freq_ok),
		.sel(cfg_r.line_freq[1:0]),
		.src(line_clock_src),
		.clk_out(line_derived_clock_output)
	);

endmodule

// ---- rtl/gpcko_clk_gate.sv ----
/*
 * Registered selector and gate for one clock output pin.
 * Assumes candidate clock levels arrive synchronous to hclk from the clock generators.
 */
module gpcko_clk_gate
	import gpcko_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic enable,
	input wire logic squelch,
	input wire logic sel_valid,
	input wire logic [1:0] sel,
	input wire logic [2:0] src,
	output logic clk_out
);

	// ----------------------------------------------------------------
	// Selection
	// ----------------------------------------------------------------
	// Reserved selections give a steady low rather than an arbitrary rate
	wire logic pick_ok = sel_valid && (sel != 2'h3);
	wire logic picked = pick_ok ? src[sel] : 1'b0;
	wire logic clk_nxt = enable && !squelch && picked;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_out <= 1'b0;
		end else begin
			clk_out <= clk_nxt;
		end
	end

endmodule

// ---- rtl/gpcko_pkg.sv ----
/*
 * Shared constants and types for the general-purpose pin and clock output control bank.
 * Assumes a 16-bit management register model carried over a 32-bit AHB-Lite slave.
 */
package gpcko_pkg;

	// ----------------------------------------------------------------
	// Register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [4:0] GPCKO_IDX_AUX = 5'h0d;
	localparam logic [4:0] GPCKO_IDX_HOLD = 5'h0e;
	localparam logic [4:0] GPCKO_IDX_ALERT = 5'h13;
	localparam logic [4:0] GPCKO_IDX_LINE = 5'h17;
	localparam logic [4:0] GPCKO_IDX_PAGE = 5'h1f;
	localparam int GPCKO_IDX_LSB = 2;
	localparam int GPCKO_IDX_MSB = 6;

	// ----------------------------------------------------------------
	// Page select values
	// ----------------------------------------------------------------
	localparam logic [15:0] GPCKO_PAGE_GENERAL = 16'h0010;
	localparam logic [15:0] GPCKO_PAGE_MAIN = 16'h0000;
	localparam logic [15:0] GPCKO_PAGE_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int GPCKO_AUX_EN_BIT = 15;
	localparam int GPCKO_AUX_FREQ_LSB = 13;
	localparam int GPCKO_HOLD_DIR_N_BIT = 13;
	localparam int GPCKO_HOLD_DATA_BIT = 12;
	localparam int GPCKO_HOLD_IN_BIT = 11;
	localparam int GPCKO_LED_TRI_BIT = 9;
	localparam int GPCKO_ALERT_LSB = 0;
	localparam int GPCKO_LINE_EN_BIT = 15;
	localparam int GPCKO_LINE_FREQ_LSB = 8;
	localparam int GPCKO_LINE_SQ_LSB = 4;
	localparam int GPCKO_LINE_SRC_LSB = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic GPCKO_AUX_EN_RST = 1'b0;
	localparam logic [1:0] GPCKO_AUX_FREQ_RST = 2'h0;
	localparam logic GPCKO_HOLD_DIR_N_RST = 1'b1;
	localparam logic GPCKO_HOLD_DATA_RST = 1'b0;
	localparam logic GPCKO_LED_TRI_RST = 1'b1;
	localparam logic [3:0] GPCKO_ALERT_RST = 4'h0;
	localparam logic GPCKO_LINE_EN_RST = 1'b0;
	localparam logic [2:0] GPCKO_LINE_FREQ_RST = 3'h0;
	localparam logic [2:0] GPCKO_LINE_SRC_RST = 3'h0;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] GPCKO_AUX_FREQ_RSVD = 2'h3;
	localparam logic [3:0] GPCKO_ALERT_ENABLED = 4'h0;
	localparam logic [2:0] GPCKO_LINE_FREQ_MAX = 3'h2;
	localparam logic [2:0] GPCKO_LINE_SRC_COPPER = 3'h1;
	localparam int GPCKO_LED_COUNT = 2;
	localparam int GPCKO_CLK_PERIOD_NS = 5;
	localparam logic [1:0] GPCKO_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] GPCKO_HTRANS_SEQ = 2'h3;
	localparam logic GPCKO_HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		GPCKO_SQ_AUTO = 2'b00,
		GPCKO_SQ_AUTO_PLUS = 2'b01,
		GPCKO_SQ_LINK_ONLY = 2'b10,
		GPCKO_SQ_NONE = 2'b11
	} gpcko_squelch_type;

	typedef enum logic [1:0] {
		GPCKO_SPEED_10 = 2'b00,
		GPCKO_SPEED_100 = 2'b01,
		GPCKO_SPEED_1000 = 2'b10,
		GPCKO_SPEED_NONE = 2'b11
	} gpcko_speed_type;

	typedef struct packed {
		logic aux_en;
		logic [1:0] aux_freq;
		logic hold_dir_n;
		logic hold_data;
		logic led_tri;
		logic [3:0] alert_sel;
		logic line_en;
		logic [2:0] line_freq;
		gpcko_squelch_type line_sq;
		logic [2:0] line_src;
	} gpcko_cfg_type;

	typedef struct packed {
		logic link_up;
		logic link_stable;
		gpcko_speed_type speed;
		logic gig_master;
		logic eee_mode;
		logic lpi_rx;
	} gpcko_link_type;

endpackage

// ---- verif/gpcko_bank_assertions.sv ----
/*
 * Port-level checker for the pin and clock output control bank.
 * Assumes hclk is the only clock and hresetn the asynchronous reset.
 */
module gpcko_bank_assertions
	import gpcko_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic soft_reset,
	input wire logic [2:0] aux_clock_src,
	input wire logic aux_clock_output,
	input wire logic low_power_hold_pin_out,
	input wire logic low_power_hold_pin_oe,
	input wire logic [GPCKO_LED_COUNT-1:0] led_level,
	input wire logic [GPCKO_LED_COUNT-1:0] led_out,
	input wire logic [GPCKO_LED_COUNT-1:0] led_oe,
	input wire logic link_loss_event,
	input wire logic link_loss_alert_pin,
	input wire logic [2:0] line_clock_src,
	input wire logic clock_mute_pin,
	input wire logic line_derived_clock_output
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ----------------------------------------------------------------
	// Sequences
	// ----------------------------------------------------------------
	// Five idle cycles let any earlier write reach the pins first
	sequence s_bus_quiet;
		!(hsel && htrans[1]) [*5];
	endsequence
	sequence s_after_release;
		$rose(hresetn);
	endsequence
	// Covers the reset value and the first cycles driven from the reset configuration
	sequence s_clocks_low;
		(!aux_clock_output && !line_derived_clock_output) [*3];
	endsequence

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_mute_squelch: assert property (clock_mute_pin |=> !line_derived_clock_output)
		else $error("line clock ran while muted");
	a_alert_gate: assert property (!link_loss_event |=> !link_loss_alert_pin)
		else $error("alert pin high without an event");
	a_led_follow: assert property (1'b1 |=> led_out == $past(led_level))
		else $error("led level not passed on");
	a_led_release: assert property ($past(hresetn) |-> (~led_oe & ~led_out) == '0)
		else $error("led released while low");
	a_aux_source: assert property (aux_clock_output |-> $past(|aux_clock_src))
		else $error("aux clock high with no source high");
	a_line_source: assert property (line_derived_clock_output |-> $past(|line_clock_src))
		else $error("line clock high with no source high");
	a_soft_keep: assert property (s_bus_quiet ##0 soft_reset |=> $stable(low_power_hold_pin_oe)
		&& $stable(low_power_hold_pin_out)) else $error("soft reset disturbed hold pin");
	a_hold_input: assert property (s_after_release |-> !low_power_hold_pin_oe [*3])
		else $error("hold pin driven after reset");
	a_reset_quiet: assert property (s_after_release |-> s_clocks_low)
		else $error("clock output running out of reset");
	a_upper_zero: assert property (hrdata[31:16] == 16'h0000 && hresp == GPCKO_HRESP_OKAY)
		else $error("upper read bits or response wrong");
endmodule

bind gpcko_bank gpcko_bank_assertions gpcko_bank_assertions_i (.*);

// ---- verif/tb_top.sv ----
/*
 * Self-checking bench for the pin and clock output control bank.
 * Assumes a zero-wait single AHB-Lite slave whose hreadyout is fed back as hready.
 */
module tb_top
	import gpcko_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, soft_reset = 1'b0, rd_pend = 1'b0;
	logic low_power_hold_pin_in = 1'b0, link_loss_event = 1'b0, clock_mute_pin = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2, aux_clock_src = 3'h0, line_clock_src = 3'h0;
	logic [GPCKO_LED_COUNT-1:0] led_level = '0, led_out, led_oe;
	gpcko_link_type link_status = '0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, aux_clock_output, low_power_hold_pin_out, low_power_hold_pin_oe;
	logic link_loss_alert_pin, line_derived_clock_output;
	logic [31:0] exp_q[$];
	int failures = 0, total_checks = 0, seed = 64444;
	logic [3:0] alert_codes [3] = '{4'h0, 4'hf, 4'h5};
	// Link states: down, 100 up, gig master, 10M, unstable, eee lpi, eee busy, gig slave
	logic [6:0] lk_vec [8] = '{7'h28, 7'h68, 7'h74, 7'h60, 7'h48, 7'h6b, 7'h6a, 7'h70};
	logic [3:0] lk_on [8] = '{4'h8, 4'hf, 4'he, 4'he, 4'hc, 4'he, 4'hc, 4'hf};

	gpcko_bank gpcko_bank_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .soft_reset(soft_reset), .aux_clock_src(aux_clock_src),
		.aux_clock_output(aux_clock_output), .low_power_hold_pin_in(low_power_hold_pin_in),
		.low_power_hold_pin_out(low_power_hold_pin_out), .low_power_hold_pin_oe(low_power_hold_pin_oe),
		.led_level(led_level), .led_out(led_out), .led_oe(led_oe), .link_loss_event(link_loss_event),
		.link_loss_alert_pin(link_loss_alert_pin), .line_clock_src(line_clock_src), .link_status(link_status),
		.clock_mute_pin(clock_mute_pin), .line_derived_clock_output(line_derived_clock_output));

	always #(GPCKO_CLK_PERIOD_NS / 2.0) hclk = ~hclk;

	// ----------------------------------------------------------------
	// Compare, bus and closing tasks
	// ----------------------------------------------------------------
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic check_pin(input logic got, input logic exp, input string what);
		check_word({31'h0, got}, {31'h0, exp}, what);
	endtask
	task automatic bus_addr(input logic [4:0] idx, input logic wr);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= GPCKO_HTRANS_NONSEQ;
		haddr <= {25'h0, idx, 2'b00};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
	endtask
	// Upper data bits are random: the bank must ignore them
	task automatic bus_write(input logic [4:0] idx, input logic [15:0] d);
		bus_addr(idx, 1'b1);
		hwdata <= {16'($random(seed)), d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask
	task automatic bus_read(input logic [4:0] idx, input logic [15:0] e);
		exp_q.push_back({16'h0, e});
		bus_addr(idx, 1'b0);
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask
	// Drives a random source pattern and its inverse, so a stuck output cannot pass
	task automatic clk_case(input logic line, input int sel, input logic on, input string what);
		logic [2:0] p;
		p = 3'($random(seed));
		for (int k = 0; k < 2; k++) begin
			if (line) line_clock_src <= p;
			else aux_clock_src <= p;
			repeat (3) @(posedge hclk);
			check_pin(line ? line_derived_clock_output : aux_clock_output, on & p[sel], what);
			p = ~p;
		end
	endtask
	task automatic results();
		if (exp_q.size() != 0) begin
			failures++;
			$display("wrong value at %0t: reads left unchecked", $time);
		end
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Read monitor and watchdog
	// ----------------------------------------------------------------
	always @(posedge hclk) begin
		if (rd_pend && hreadyout === 1'b1) begin
			check_word(hrdata, exp_q.pop_front(), "read data");
		end
		rd_pend <= hresetn && hsel && hreadyout && htrans[1] && !hwrite;
	end
	initial begin
		repeat (40000) @(posedge hclk);
		failures++;
		$display("wrong value at %0t: run did not finish", $time);
		results();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		bus_write(GPCKO_IDX_PAGE, GPCKO_PAGE_GENERAL);
		bus_read(GPCKO_IDX_PAGE, GPCKO_PAGE_GENERAL);
		bus_read(GPCKO_IDX_AUX, 16'h0000);
		bus_read(GPCKO_IDX_HOLD, 16'h2200);
		bus_read(GPCKO_IDX_ALERT, 16'h0000);
		bus_read(GPCKO_IDX_LINE, 16'h0000);
		bus_write(5'h01, 16'hffff);
		bus_read(5'h01, 16'h0000);
		bus_write(GPCKO_IDX_AUX, 16'hffff);
		bus_read(GPCKO_IDX_AUX, 16'he000);
		for (int f = 0; f < 4; f++) begin
			bus_write(GPCKO_IDX_AUX, {1'b1, 2'(f), 13'h0});
			clk_case(1'b0, f % 3, f < 3, "aux clock");
		end
		bus_write(GPCKO_IDX_AUX, 16'h2000);
		clk_case(1'b0, 1, 1'b0, "aux disabled");
		bus_write(GPCKO_IDX_HOLD, 16'h1000);
		low_power_hold_pin_in <= 1'b1;
		led_level <= 2'($random(seed));
		repeat (3) @(posedge hclk);
		check_pin(low_power_hold_pin_oe, 1'b1, "hold oe");
		check_pin(low_power_hold_pin_out, 1'b1, "hold out");
		check_word(32'(led_oe), 32'h3, "led driven");
		bus_read(GPCKO_IDX_HOLD, 16'h1800);
		bus_write(GPCKO_IDX_HOLD, 16'hffff);
		low_power_hold_pin_in <= 1'b0;
		repeat (3) @(posedge hclk);
		check_pin(low_power_hold_pin_oe, 1'b0, "hold released");
		check_word(32'(led_oe), 32'({~led_level}), "led tristate");
		bus_read(GPCKO_IDX_HOLD, 16'h3200);
		link_loss_event <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			bus_write(GPCKO_IDX_ALERT, {12'h0, alert_codes[i]});
			repeat (3) @(posedge hclk);
			check_pin(link_loss_alert_pin, alert_codes[i] == GPCKO_ALERT_ENABLED, "alert pin");
			bus_read(GPCKO_IDX_ALERT, {12'h0, alert_codes[i]});
		end
		for (int sq = 0; sq < 4; sq++) begin
			bus_write(GPCKO_IDX_LINE, {1'b1, 4'h0, 3'h1, 2'b00, 2'(sq), 1'b0, 3'h1});
			for (int i = 0; i < 8; i++) begin
				link_status <= gpcko_link_type'(lk_vec[i]);
				clk_case(1'b1, 1, lk_on[i][sq], "line squelch");
			end
		end
		for (int f = 0; f < 4; f++) begin
			bus_write(GPCKO_IDX_LINE, {1'b1, 4'h0, 3'(f), 2'b00, 2'b11, 1'b0, 3'h1});
			clk_case(1'b1, f % 3, f < 3, "line freq");
		end
		bus_write(GPCKO_IDX_LINE, 16'h8030);
		clk_case(1'b1, 0, 1'b0, "line source");
		bus_write(GPCKO_IDX_LINE, 16'h0031);
		clk_case(1'b1, 0, 1'b0, "line disabled");
		bus_write(GPCKO_IDX_LINE, 16'hffff);
		bus_read(GPCKO_IDX_LINE, 16'h8737);
		bus_write(GPCKO_IDX_LINE, 16'h8031);
		clock_mute_pin <= 1'b1;
		clk_case(1'b1, 0, 1'b0, "line muted");
		clock_mute_pin <= 1'b0;
		clk_case(1'b1, 0, 1'b1, "line unmuted");
		repeat (6) @(posedge hclk);
		soft_reset <= 1'b1;
		@(posedge hclk);
		soft_reset <= 1'b0;
		bus_read(GPCKO_IDX_LINE, 16'h0000);
		bus_write(GPCKO_IDX_PAGE, GPCKO_PAGE_GENERAL);
		bus_read(GPCKO_IDX_LINE, 16'h8031);
		bus_read(GPCKO_IDX_HOLD, 16'h3200);
		bus_write(GPCKO_IDX_PAGE, GPCKO_PAGE_MAIN);
		bus_read(GPCKO_IDX_LINE, 16'h0000);
		hresetn <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		bus_write(GPCKO_IDX_PAGE, GPCKO_PAGE_GENERAL);
		bus_read(GPCKO_IDX_LINE, 16'h0000);
		// Let the read monitor take the last data phase before the run ends
		repeat (2) @(posedge hclk);
		results();
	end
endmodule
